// ---- logic/ipl_codec.sv ----
// Inductive power link codec: FSK sender, bridge gate drive and ASK packet decoder
// Notes on behaviour
// - Frequency changes only at boundaries of 256-switching-cycle blocks.
// - Start bit is 512 cycles at the modulated frequency.
// - A one is 256 cycles at one frequency then 256 at the other.
// - A zero is 512 cycles at one frequency without change.
// - Outgoing byte framed as start, data, parity, stop.
// - Incoming load modulation is 2 kbps; decoder timing built on that.
// - Two narrow transitions within a bit period decode as one.
// - A single wide transition in a bit period decodes as zero.
// - Incoming byte is start, 8 data, parity, stop: 11 bits.
// - Packet is preamble, header, message bytes, checksum.
// - One packet decoder serves voltage and current envelope paths.
// - Packet decoder takes the path giving the better demodulated signal.
// - Programmable dead time per half bridge; high and low never both on.
// - Each half-bridge group enabled on its own: full or half bridge.
// - Each group drives a complementary high and low gate pair.
`timescale 1ns/1ps
`include "ipl_defs.svh"
module ipl_codec #(
  parameter int ASK_BIT_CLKS = `IPL_ASK_BIT_CLKS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [15:0] base_half_clks,
  input wire logic [15:0] mod_half_clks,
  input wire logic [15:0] phase_shift_clks,
  input wire logic leg_a_en,
  input wire logic leg_b_en,
  input wire logic [7:0] dead_a_clks,
  input wire logic [7:0] dead_b_clks,
  output logic gate_a_hi,
  output logic gate_a_lo,
  output logic gate_b_hi,
  output logic gate_b_lo,
  input wire logic [7:0] fsk_data,
  input wire logic fsk_valid,
  output logic fsk_ready,
  output logic fsk_mod_active,
  input wire logic coil_voltage_envelope_input,
  input wire logic supply_current_envelope_input,
  output logic pkt_valid,
  output logic pkt_err,
  output logic [4:0] pkt_len,
  input wire logic [4:0] pkt_rd_idx,
  output logic [7:0] pkt_rd_data,
  output logic src_is_current
);
  ipl_pkg::ipl_top_st_t st_r;
  ipl_pkg::ipl_top_st_t st_nxt;
  ipl_bit_if cv ();
  ipl_bit_if ci ();
  logic [16:0] half;
  logic [16:0] period;
  logic sw_wrap;
  logic blk_wrap;
  logic bv;
  logic bval;
  logic berr;

  ipl_bit_dec #(.BIT_CLKS(ASK_BIT_CLKS)) u_dec_v (
    .clk(clk),
    .nrst(nrst),
    .env_in(coil_voltage_envelope_input),
    .bo(cv)
  );
  ipl_bit_dec #(.BIT_CLKS(ASK_BIT_CLKS)) u_dec_i (
    .clk(clk),
    .nrst(nrst),
    .env_in(supply_current_envelope_input),
    .bo(ci)
  );

  function automatic logic phase_on(logic [16:0] cnt, logic [16:0] sh, logic [16:0] per,
                                    logic [16:0] hp);
    logic [16:0] p;
    p = (cnt >= sh) ? cnt - sh : cnt + per - sh;
    return p < hp;
  endfunction

  // Gates drop at once on a change of wanted side; the other side waits out the dead time
  function automatic ipl_pkg::ipl_leg_t leg_step(ipl_pkg::ipl_leg_t s, logic want, logic en,
                                                 logic [7:0] dead);
    ipl_pkg::ipl_leg_t n;
    n = s;
    n.hi = 1'b0;
    n.lo = 1'b0;
    if (want != s.des)
    begin
      n.des = want;
      n.dt = dead;
    end
    else if (s.dt != 8'h00)
      n.dt = s.dt - 8'h01;
    else
    begin
      n.hi = en & s.des;
      n.lo = en & ~s.des;
    end
    return n;
  endfunction

  function automatic logic [3:0] score_upd(logic [3:0] s, logic v, logic e);
    if (e)
      return 4'h0;
    if (v && s != 4'hf)
      return s + 4'h1;
    return s;
  endfunction

  assign half = {1'b0, st_r.mod_sel ? mod_half_clks : base_half_clks};
  assign period = {half[15:0], 1'b0};
  assign sw_wrap = st_r.sw_cnt >= period - 17'h1;
  assign blk_wrap = sw_wrap && st_r.blk_cnt == `IPL_FSK_BLOCK_LAST;
  assign fsk_ready = st_r.tx_st == ipl_pkg::IPL_TX_IDLE && blk_wrap;
  assign bv = st_r.src_sel ? ci.bit_valid : cv.bit_valid;
  assign bval = st_r.src_sel ? ci.bit_val : cv.bit_val;
  assign berr = st_r.src_sel ? ci.bit_err : cv.bit_err;
  assign gate_a_hi = st_r.leg_a.hi;
  assign gate_a_lo = st_r.leg_a.lo;
  assign gate_b_hi = st_r.leg_b.hi;
  assign gate_b_lo = st_r.leg_b.lo;
  assign fsk_mod_active = st_r.mod_sel;
  assign pkt_valid = st_r.pkt_valid;
  assign pkt_err = st_r.pkt_err;
  assign pkt_len = st_r.pkt_len;
  assign pkt_rd_data = st_r.rd_data;
  assign src_is_current = st_r.src_sel;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.pkt_valid = 1'b0;
    st_nxt.pkt_err = 1'b0;
    st_nxt.rd_data = (pkt_rd_idx < 5'(`IPL_MAX_BYTES)) ? st_r.pbuf[pkt_rd_idx] : 8'h00;
    // Switching-cycle counter; the period follows the half-period inputs on every clock
    st_nxt.sw_cnt = sw_wrap ? 17'h0 : st_r.sw_cnt + 17'h1;
    if (sw_wrap)
      st_nxt.blk_cnt = st_r.blk_cnt + 8'h01;
    st_nxt.leg_a = leg_step(st_r.leg_a, phase_on(st_r.sw_cnt, 17'h0, period, half),
                            leg_a_en, dead_a_clks);
    st_nxt.leg_b = leg_step(st_r.leg_b, phase_on(st_r.sw_cnt, {1'b0, phase_shift_clks},
                            period, half), leg_b_en, dead_b_clks);
    unique case (st_r.tx_st)
      ipl_pkg::IPL_TX_IDLE:
      begin
        if (fsk_valid && blk_wrap)
        begin
          st_nxt.tx_sh = {1'b1, ~^fsk_data, fsk_data, 1'b0};
          st_nxt.mod_sel = 1'b1;
          st_nxt.tx_left = `IPL_FSK_BITS;
          st_nxt.tx_ph = 1'b0;
          st_nxt.tx_st = ipl_pkg::IPL_TX_SEND;
        end
      end
      ipl_pkg::IPL_TX_SEND:
      begin
        if (blk_wrap && !st_r.tx_ph)
        begin
          st_nxt.tx_ph = 1'b1;
          if (st_r.tx_sh[0])
            st_nxt.mod_sel = ~st_r.mod_sel;
        end
        else if (blk_wrap)
        begin
          // A zero keeps its frequency across both halves
          st_nxt.tx_ph = 1'b0;
          st_nxt.tx_sh = {1'b0, st_r.tx_sh[10:1]};
          st_nxt.tx_left = st_r.tx_left - 4'h1;
          if (st_r.tx_left == 4'h1)
          begin
            st_nxt.mod_sel = 1'b0;
            st_nxt.tx_st = ipl_pkg::IPL_TX_IDLE;
          end
        end
      end
      default:
        st_nxt.tx_st = ipl_pkg::IPL_TX_IDLE;
    endcase
    st_nxt.score_v = score_upd(st_r.score_v, cv.bit_valid, cv.bit_err);
    st_nxt.score_i = score_upd(st_r.score_i, ci.bit_valid, ci.bit_err);
    unique case (st_r.rx_st)
      ipl_pkg::IPL_RX_HUNT:
      begin
        // Source may only move while no packet is being taken
        st_nxt.src_sel = st_r.score_i > st_r.score_v;
        if (berr)
          st_nxt.pre_cnt = 4'h0;
        else if (bv && bval)
          st_nxt.pre_cnt = (st_r.pre_cnt == 4'hf) ? 4'hf : st_r.pre_cnt + 4'h1;
        else if (bv && st_r.pre_cnt >= `IPL_PREAMBLE_MIN)
        begin
          st_nxt.rx_st = ipl_pkg::IPL_RX_BYTE;
          st_nxt.bit_idx = 4'h0;
          st_nxt.nbytes = 5'h0;
          st_nxt.csum = 8'h00;
          st_nxt.pre_cnt = 4'h0;
        end
        else if (bv)
          st_nxt.pre_cnt = 4'h0;
      end
      ipl_pkg::IPL_RX_BYTE:
      begin
        if (berr)
        begin
          st_nxt.pkt_err = 1'b1;
          st_nxt.rx_st = ipl_pkg::IPL_RX_HUNT;
        end
        else if (bv && st_r.bit_idx != `IPL_RX_STOP_IDX)
        begin
          st_nxt.sh = {bval, st_r.sh[8:1]};
          st_nxt.bit_idx = st_r.bit_idx + 4'h1;
        end
        else if (bv && bval && ^st_r.sh && st_r.nbytes < 5'(`IPL_MAX_BYTES))
        begin
          st_nxt.pbuf[st_r.nbytes] = st_r.sh[7:0];
          st_nxt.csum = st_r.csum ^ st_r.sh[7:0];
          st_nxt.nbytes = st_r.nbytes + 5'h1;
          st_nxt.rx_st = ipl_pkg::IPL_RX_GAP;
        end
        else if (bv)
        begin
          st_nxt.pkt_err = 1'b1;
          st_nxt.rx_st = ipl_pkg::IPL_RX_HUNT;
        end
      end
      ipl_pkg::IPL_RX_GAP:
      begin
        if (berr)
        begin
          // Silence after a stop bit closes the packet; the last byte is the checksum
          if (st_r.nbytes >= `IPL_MIN_PKT_BYTES && st_r.csum == 8'h00)
          begin
            st_nxt.pkt_valid = 1'b1;
            st_nxt.pkt_len = st_r.nbytes;
          end
          else
            st_nxt.pkt_err = 1'b1;
          st_nxt.rx_st = ipl_pkg::IPL_RX_HUNT;
        end
        else if (bv && !bval)
        begin
          st_nxt.bit_idx = 4'h0;
          st_nxt.rx_st = ipl_pkg::IPL_RX_BYTE;
        end
        else if (bv)
        begin
          st_nxt.pkt_err = 1'b1;
          st_nxt.rx_st = ipl_pkg::IPL_RX_HUNT;
        end
      end
      default:
        st_nxt.rx_st = ipl_pkg::IPL_RX_HUNT;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_r <= '0;
      st_r.tx_st <= ipl_pkg::IPL_TX_IDLE;
      st_r.rx_st <= ipl_pkg::IPL_RX_HUNT;
    end
    else
      st_r <= st_nxt;
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_tx_start;
    fsk_valid && fsk_ready;
  endsequence
  sequence s_mid_change;
    $changed(st_r.mod_sel) && st_r.tx_st == ipl_pkg::IPL_TX_SEND && st_r.tx_ph;
  endsequence

  chk_no_shoot_a: assert property (!(gate_a_hi && gate_a_lo) && !(gate_b_hi && gate_b_lo))
    else $error("high and low gate on together");
  chk_dead_gap_a: assert property ($fell(gate_a_hi) && dead_a_clks != 8'h00 |->
    !gate_a_lo ##1 !gate_a_lo)
    else $error("low gate on without dead time");
  chk_leg_off_b: assert property (!leg_b_en |=> !gate_b_hi && !gate_b_lo)
    else $error("disabled half bridge still driven");
  chk_fsk_block_edge: assert property ($changed(st_r.mod_sel) |-> st_r.blk_cnt == 8'h00)
    else $error("frequency change off a block boundary");
  chk_start_mod: assert property (s_tx_start |=> st_r.mod_sel [*8])
    else $error("start bit not at modulated frequency");
  chk_one_toggle: assert property (s_mid_change |-> $past(st_r.tx_sh[0]))
    else $error("mid-bit change on a zero");
  chk_tx_frame: assert property (s_tx_start |=>
    st_r.tx_sh == {1'b1, ~^$past(fsk_data), $past(fsk_data), 1'b0})
    else $error("outgoing frame or parity wrong");
  chk_pkt_csum: assert property (pkt_valid |-> st_r.csum == 8'h00 && pkt_len >= 5'h02)
    else $error("packet accepted with bad checksum");
  chk_src_lock: assert property (st_r.rx_st != ipl_pkg::IPL_RX_HUNT |=> $stable(st_r.src_sel))
    else $error("source switched during a packet");
  chk_byte_bits: assert property (st_r.bit_idx <= `IPL_RX_STOP_IDX)
    else $error("byte bit index past the stop bit");
endmodule

// ---- logic/ipl_defs.svh ----
// Timing counts, framing figures and sizes of the inductive power link codec
`ifndef IPL_DEFS_SVH
`define IPL_DEFS_SVH
`define IPL_CLK_NS 10
`define IPL_ASK_BIT_NS 500000
`define IPL_ASK_BIT_CLKS (`IPL_ASK_BIT_NS / `IPL_CLK_NS)
`define IPL_FSK_BLOCK_LAST 8'hff
`define IPL_FSK_BITS 4'hb
`define IPL_RX_STOP_IDX 4'h9
`define IPL_PREAMBLE_MIN 4'h4
`define IPL_MAX_BYTES 28
`define IPL_MIN_PKT_BYTES 5'h02
`endif

// ---- logic/ipl_pkg.sv ----
// Types shared by the inductive power link codec modules
`include "ipl_defs.svh"
package ipl_pkg;
  typedef enum logic [1:0] {IPL_TX_IDLE = 2'b01, IPL_TX_SEND = 2'b10} ipl_tx_st_t;
  typedef enum logic [2:0] {
    IPL_RX_HUNT = 3'b001,
    IPL_RX_BYTE = 3'b010,
    IPL_RX_GAP = 3'b100
  } ipl_rx_st_t;
  typedef struct packed {
    logic des;
    logic [7:0] dt;
    logic hi;
    logic lo;
  } ipl_leg_t;
  typedef struct packed {
    logic act;
    logic prev;
    logic pend;
    logic [19:0] cnt;
    logic bv;
    logic bval;
    logic berr;
  } ipl_dec_st_t;
  typedef struct packed {
    logic [16:0] sw_cnt;
    logic mod_sel;
    logic [7:0] blk_cnt;
    ipl_tx_st_t tx_st;
    logic [10:0] tx_sh;
    logic [3:0] tx_left;
    logic tx_ph;
    ipl_leg_t leg_a;
    ipl_leg_t leg_b;
    ipl_rx_st_t rx_st;
    logic [3:0] pre_cnt;
    logic [3:0] bit_idx;
    logic [8:0] sh;
    logic [4:0] nbytes;
    logic [7:0] csum;
    logic [`IPL_MAX_BYTES-1:0][7:0] pbuf;
    logic src_sel;
    logic [3:0] score_v;
    logic [3:0] score_i;
    logic pkt_valid;
    logic pkt_err;
    logic [4:0] pkt_len;
    logic [7:0] rd_data;
  } ipl_top_st_t;
endpackage

// ---- logic/ipl_bit_if.sv ----
// Decoded bit events passed from an envelope bit decoder to the packet decoder
`timescale 1ns/1ps
interface ipl_bit_if;
  logic bit_valid;
  logic bit_val;
  logic bit_err;
  modport dec (output bit_valid, output bit_val, output bit_err);
  modport pkt (input bit_valid, input bit_val, input bit_err);
endinterface

// ---- logic/ipl_bit_dec.sv ----
// Differential bi-phase bit decoder for one demodulated envelope
`timescale 1ns/1ps
`include "ipl_defs.svh"
module ipl_bit_dec #(
  parameter int BIT_CLKS = `IPL_ASK_BIT_CLKS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic env_in,
  ipl_bit_if.dec bo
);
  localparam logic [19:0] QTR = 20'(BIT_CLKS / 4);
  localparam logic [19:0] HALF_MAX = 20'(3 * (BIT_CLKS / 4));
  localparam logic [19:0] FULL_MAX = 20'(5 * (BIT_CLKS / 4));

  ipl_pkg::ipl_dec_st_t st_r;
  ipl_pkg::ipl_dec_st_t st_nxt;
  logic edge_seen;

  assign edge_seen = env_in != st_r.prev;
  assign bo.bit_valid = st_r.bv;
  assign bo.bit_val = st_r.bval;
  assign bo.bit_err = st_r.berr;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.prev = env_in;
    st_nxt.bv = 1'b0;
    st_nxt.berr = 1'b0;
    if (st_r.act && st_r.cnt != 20'hfffff)
      st_nxt.cnt = st_r.cnt + 20'h1;
    if (!st_r.act)
    begin
      // The first edge after silence only opens timing; it carries no bit
      if (edge_seen)
      begin
        st_nxt.act = 1'b1;
        st_nxt.cnt = 20'h0;
        st_nxt.pend = 1'b0;
      end
    end
    else if (edge_seen)
    begin
      st_nxt.cnt = 20'h0;
      if (st_r.cnt < QTR)
      begin
        st_nxt.berr = 1'b1;
        st_nxt.act = 1'b0;
      end
      else if (st_r.cnt < HALF_MAX)
      begin
        if (st_r.pend)
        begin
          st_nxt.bv = 1'b1;
          st_nxt.bval = 1'b1;
          st_nxt.pend = 1'b0;
        end
        else
          st_nxt.pend = 1'b1;
      end
      else if (!st_r.pend)
      begin
        st_nxt.bv = 1'b1;
        st_nxt.bval = 1'b0;
      end
      else
      begin
        st_nxt.berr = 1'b1;
        st_nxt.act = 1'b0;
      end
    end
    else if (st_r.cnt >= FULL_MAX)
    begin
      // Silence of a bit and a quarter ends the burst; the packet side uses this
      st_nxt.berr = 1'b1;
      st_nxt.act = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_bit_spacing: assert property (bo.bit_valid |=> !bo.bit_valid [*8])
    else $error("bit events closer than a quarter bit");
  chk_one_pairs: assert property (bo.bit_valid && bo.bit_val |-> $past(st_r.pend))
    else $error("one reported without a preceding narrow interval");
  chk_zero_wide: assert property (bo.bit_valid && !bo.bit_val |-> !$past(st_r.pend))
    else $error("zero reported after a pending narrow interval");
endmodule

// ---- tb/ipl_rx_model.sv ----
// Behavioural wireless power receiver: load-modulates packets onto one envelope path
`timescale 1ns/1ps
module ipl_rx_model #(
  parameter int BIT_CLKS = 40
) (
  input wire logic clk,
  output logic env_v,
  output logic env_i
);
  initial
  begin
    env_v = 1'b0;
    env_i = 1'b0;
  end

  task automatic flip_after(input logic cur, input int n);
    repeat (n) @(posedge clk);
    #1;
    if (cur) env_i = ~env_i;
    else env_v = ~env_v;
  endtask

  // Every bit ends on a transition; a one adds one in mid bit
  task automatic send_bit(input logic cur, input logic b);
    if (b)
    begin
      flip_after(cur, BIT_CLKS / 2);
      flip_after(cur, BIT_CLKS / 2);
    end
    else flip_after(cur, BIT_CLKS);
  endtask

  // The opening edge only starts timing; the line then rests to end the packet
  task automatic send_pkt(input logic cur, input logic [7:0] pkt [4], input int n,
                          input logic bad_par);
    flip_after(cur, 1);
    repeat (8) send_bit(cur, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      send_bit(cur, 1'b0);
      for (int j = 0; j < 8; j++) send_bit(cur, pkt[i][j]);
      send_bit(cur, (~^pkt[i]) ^ (bad_par && i == n - 1));
      send_bit(cur, 1'b1);
    end
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the inductive power link codec
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic nrst;
  logic [15:0] base_half_clks, mod_half_clks, phase_shift_clks;
  logic leg_a_en, leg_b_en;
  logic [7:0] dead_a_clks, dead_b_clks;
  logic gate_a_hi, gate_a_lo, gate_b_hi, gate_b_lo;
  logic [7:0] fsk_data;
  logic fsk_valid, fsk_ready, fsk_mod_active;
  logic env_v, env_i;
  logic pkt_valid, pkt_err, src_is_current;
  logic [4:0] pkt_len, pkt_rd_idx;
  logic [7:0] pkt_rd_data;
  logic [7:0] pkt [4];
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int off_run = 0;
  logic armed = 1'b0;
  logic mon_dead = 1'b0;
  logic sa_hi, sa_lo, sb_hi, sb_lo;

  always #5 clk = ~clk;

  ipl_codec #(.ASK_BIT_CLKS(40)) ipl_codec_inst (
    .clk(clk), .nrst(nrst), .base_half_clks(base_half_clks), .mod_half_clks(mod_half_clks),
    .phase_shift_clks(phase_shift_clks), .leg_a_en(leg_a_en), .leg_b_en(leg_b_en),
    .dead_a_clks(dead_a_clks), .dead_b_clks(dead_b_clks), .gate_a_hi(gate_a_hi),
    .gate_a_lo(gate_a_lo), .gate_b_hi(gate_b_hi), .gate_b_lo(gate_b_lo),
    .fsk_data(fsk_data), .fsk_valid(fsk_valid), .fsk_ready(fsk_ready),
    .fsk_mod_active(fsk_mod_active), .coil_voltage_envelope_input(env_v),
    .supply_current_envelope_input(env_i), .pkt_valid(pkt_valid), .pkt_err(pkt_err),
    .pkt_len(pkt_len), .pkt_rd_idx(pkt_rd_idx), .pkt_rd_data(pkt_rd_data),
    .src_is_current(src_is_current)
  );

  ipl_rx_model #(.BIT_CLKS(40)) ipl_rx_model_inst (.clk(clk), .env_v(env_v), .env_i(env_i));

  task automatic finish_test;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Gates are looked at mid-cycle so registered updates have settled
  always @(negedge clk)
  begin
    if (nrst === 1'b1)
    begin
      chk_bit(gate_a_hi & gate_a_lo, 1'b0);
      chk_bit(gate_b_hi & gate_b_lo, 1'b0);
    end
    if (mon_dead && (gate_a_hi || gate_a_lo))
    begin
      if (armed && off_run > 0) chk_byte(8'(off_run), dead_a_clks + 8'h01);
      armed = 1'b1;
      off_run = 0;
    end
    else if (mon_dead) off_run++;
    else
    begin
      armed = 1'b0;
      off_run = 0;
    end
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_errors++;
      finish_test();
    end
  end

  task automatic watch(input int n);
    {sa_hi, sa_lo, sb_hi, sb_lo} = 4'h0;
    repeat (n) @(negedge clk)
    begin
      sa_hi |= gate_a_hi;
      sa_lo |= gate_a_lo;
      sb_hi |= gate_b_hi;
      sb_lo |= gate_b_lo;
    end
    @(posedge clk);
    #1;
  endtask

  // Expected frequency per 256-cycle block is rebuilt from the byte itself
  task automatic fsk_send(input logic [7:0] d);
    logic [10:0] bits;
    logic f;
    int k;
    bits = {1'b1, ~^d, d, 1'b0};
    fsk_data = d;
    fsk_valid = 1'b1;
    k = 0;
    while (fsk_ready !== 1'b1 && k < 2000)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk_bit(fsk_ready, 1'b1);
    @(posedge clk);
    #1;
    fsk_valid = 1'b0;
    f = 1'b1;
    repeat (256) @(posedge clk);
    for (k = 0; k < 23; k++)
    begin
      if (k == 22) f = 1'b0;
      else if (k % 2 == 1 && k > 1 && bits[k / 2]) f = ~f;
      chk_bit(fsk_mod_active, f);
      repeat (512) @(posedge clk);
    end
  endtask

  task automatic ask_case(input logic cur, input int n, input logic bad, input logic ok,
                          input logic [4:0] len);
    int k;
    ipl_rx_model_inst.send_pkt(cur, pkt, n, bad);
    k = 0;
    while (pkt_valid !== 1'b1 && pkt_err !== 1'b1 && k < 300)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk_bit(pkt_valid, ok);
    chk_bit(pkt_err, ~ok);
    // Choice is only held while a packet is open; hunting re-scores both paths
    if (ok) chk_bit(src_is_current, cur);
    chk_byte({3'h0, pkt_len}, {3'h0, len});
    for (int i = 0; i < 4 && ok; i++)
    begin
      pkt_rd_idx = 5'(i);
      @(posedge clk);
      #1;
      if (i < n) chk_byte(pkt_rd_data, pkt[i]);
    end
    repeat (100) @(posedge clk);
    #1;
  endtask

  initial
  begin
    nrst = 1'b0;
    {leg_a_en, leg_b_en, fsk_valid} = 3'h0;
    {base_half_clks, mod_half_clks, phase_shift_clks} = {16'h0008, 16'h0008, 16'h0004};
    {dead_a_clks, dead_b_clks, fsk_data, pkt_rd_idx} = {8'h02, 8'h03, 8'h00, 5'h00};
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    chk_bit(gate_a_hi | gate_a_lo | gate_b_hi | gate_b_lo, 1'b0);
    chk_bit(fsk_mod_active | pkt_valid | pkt_err | src_is_current, 1'b0);
    $display("test reset done");
    leg_a_en = 1'b1;
    mon_dead = 1'b1;
    watch(200);
    chk_bit(sa_hi & sa_lo, 1'b1);
    chk_bit(sb_hi | sb_lo, 1'b0);
    {leg_a_en, leg_b_en, mon_dead} = 3'b010;
    @(posedge clk);
    #1;
    watch(200);
    chk_bit(sb_hi & sb_lo, 1'b1);
    chk_bit(sa_hi | sa_lo, 1'b0);
    $display("test bridge done");
    // Short switching periods keep a whole byte near eleven thousand cycles
    {leg_a_en, leg_b_en, dead_a_clks} = {2'b10, 8'h01};
    {base_half_clks, mod_half_clks, phase_shift_clks} = {16'h0001, 16'h0001, 16'h0000};
    fsk_send(8'ha5);
    $display("test fsk done");
    pkt = '{8'h05, 8'h3c, 8'h39, 8'h00};
    ask_case(1'b0, 3, 1'b0, 1'b1, 5'h03);
    pkt[2] = 8'h38;
    ask_case(1'b0, 3, 1'b0, 1'b0, 5'h03);
    pkt[2] = 8'h39;
    ask_case(1'b0, 3, 1'b1, 1'b0, 5'h03);
    pkt = '{8'h11, 8'h22, 8'h44, 8'h77};
    ask_case(1'b1, 4, 1'b0, 1'b1, 5'h04);
    $display("test ask done");
    finish_test();
  end
endmodule
